//--- src/lpm_link_pin_mode_control.sv
// Purpose: Mode and output-value control of the link pins on both link ports.
// Assumes: Remote levels and link detect are synchronous to clk.
// Notes: Pins per port: one, two, three (remote capable), five, six (register only).
`timescale 1ns/1ps
module lpm_link_pin_mode_control (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic second_port_select,
  input wire lpm_pkg::lpm_req_t req,
  output logic [7:0] rdata,
  input wire logic [1:0] link_detect,
  input wire logic [1:0] remote_valid,
  input wire logic [1:0][2:0] remote_level,
  input wire logic [1:0][4:0] pin_in,
  output logic [1:0][4:0] pin_out,
  output logic [1:0][4:0] pin_oe,
  output logic [1:0][4:0] pin_sampled,
  output logic [1:0][2:0] functional_in
);

  lpm_pkg::lpm_state_t state;
  lpm_pkg::lpm_state_t next_state;
  logic [1:0][4:0] pin_meta;
  logic [1:0][4:0] pin_sync;
  logic port;

  // ----------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  assign port = second_port_select;

  // Decodes one three-bit remote-capable pin; oe, out in {drive, level}.
  function automatic logic [1:0] decode3(input logic [2:0] mode, input logic value,
                                         input logic link, input logic held,
                                         input logic rem);
    logic [1:0] r;
    r = 2'b00;
    case (mode)
      lpm_pkg::MODE_LOCAL_OUT: r = {1'b1, value};
      lpm_pkg::MODE_REMOTE_HOLD: r = {1'b1, link ? rem : held};
      lpm_pkg::MODE_REMOTE_DEFAULT: r = {1'b1, link ? rem : value};
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  // Decodes one two-bit register-only pin.
  function automatic logic [1:0] decode2(input logic [1:0] mode, input logic value);
    logic [1:0] r;
    r = 2'b00;
    case (mode)
      lpm_pkg::SHORT_OUT: r = {1'b1, value};
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] m1;
    logic [2:0] m2;
    logic [2:0] m3;
    logic [1:0] d;
    logic [7:0] sel;
    next_state = state;
    m1 = '0;
    m2 = '0;
    m3 = '0;
    d = '0;
    sel = '0;
    if (req.wr) begin
      case (req.addr)
        lpm_pkg::PAIR_ONE_TWO_OFFSET: next_state.cfg[port].pair_one_two = req.wdata;
        lpm_pkg::PIN_THREE_OFFSET: next_state.cfg[port].pin_three = {4'h0, req.wdata[3:0]};
        lpm_pkg::PAIR_FIVE_SIX_OFFSET: next_state.cfg[port].pair_five_six =
          {req.wdata[7], 1'b0, req.wdata[5:4], req.wdata[3], 1'b0, req.wdata[1:0]};
        default: next_state.cfg = state.cfg;
      endcase
    end
    case (req.addr)
      lpm_pkg::PAIR_ONE_TWO_OFFSET: sel = state.cfg[port].pair_one_two;
      lpm_pkg::PIN_THREE_OFFSET: sel = state.cfg[port].pin_three;
      lpm_pkg::PAIR_FIVE_SIX_OFFSET: sel = state.cfg[port].pair_five_six;
      default: sel = 8'h00;
    endcase
    next_state.rdata = req.rd ? sel : state.rdata;
    for (int p = 0; p < 2; p++) begin
      if (remote_valid[p]) begin
        next_state.remote_level[p] = remote_level[p];
      end
      m1 = state.cfg[p].pair_one_two[lpm_pkg::LO_MODE_LSB +: 3];
      m2 = state.cfg[p].pair_one_two[lpm_pkg::HI_MODE_LSB +: 3];
      m3 = state.cfg[p].pin_three[lpm_pkg::LO_MODE_LSB +: 3];
      d = decode3(m1, state.cfg[p].pair_one_two[lpm_pkg::LO_VALUE_BIT], link_detect[p],
                  state.held_level[p][0], state.remote_level[p][0]);
      next_state.pin_oe[p][0] = d[1];
      next_state.pin_out[p][0] = d[0];
      d = decode3(m2, state.cfg[p].pair_one_two[lpm_pkg::HI_VALUE_BIT], link_detect[p],
                  state.held_level[p][1], state.remote_level[p][1]);
      next_state.pin_oe[p][1] = d[1];
      next_state.pin_out[p][1] = d[0];
      d = decode3(m3, state.cfg[p].pin_three[lpm_pkg::LO_VALUE_BIT], link_detect[p],
                  state.held_level[p][2], state.remote_level[p][2]);
      next_state.pin_oe[p][2] = d[1];
      next_state.pin_out[p][2] = d[0];
      d = decode2(state.cfg[p].pair_five_six[1:0],
                  state.cfg[p].pair_five_six[lpm_pkg::LO_VALUE_BIT]);
      next_state.pin_oe[p][3] = d[1];
      next_state.pin_out[p][3] = d[0];
      d = decode2(state.cfg[p].pair_five_six[5:4],
                  state.cfg[p].pair_five_six[lpm_pkg::HI_VALUE_BIT]);
      next_state.pin_oe[p][4] = d[1];
      next_state.pin_out[p][4] = d[0];
      // The held level follows the remote level while linked, so link loss freezes it.
      if (link_detect[p]) begin
        next_state.held_level[p] = state.remote_level[p];
      end
      next_state.pin_sampled[p] = pin_sync[p];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rdata = state.rdata;
  assign pin_out = state.pin_out;
  assign pin_oe = state.pin_oe;
  assign pin_sampled = state.pin_sampled;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      functional_in[p][0] = 1'b0;
      functional_in[p][1] =
        (state.cfg[p].pair_one_two[5:4] == lpm_pkg::MODE_FUNC_IN_LOW);
      functional_in[p][2] =
        (state.cfg[p].pin_three[1:0] == lpm_pkg::MODE_FUNC_IN_LOW);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence link_lost_s;
    $fell(link_detect[0]);
  endsequence

  local_out_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.cfg[0].pair_one_two[2:0] == 3'h1 |=> pin_oe[0][0] &&
      pin_out[0][0] == $past(state.cfg[0].pair_one_two[3]))
    else $error("pin one local output wrong");
  tristate_even_a: assert property (@(posedge clk) disable iff (!arst_n)
    !state.cfg[0].pair_one_two[0] |=> !pin_oe[0][0])
    else $error("pin one not tri-stated");
  pin_two_hiz_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.cfg[0].pair_one_two[5:4] == 2'h2 |-> !functional_in[0][1] ##1 !pin_oe[0][1])
    else $error("pin two not high impedance");
  pin_three_func_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.cfg[0].pin_three[1:0] == 2'h0 |-> functional_in[0][2] ##1 !pin_oe[0][2])
    else $error("pin three functional input wrong");
  local_in_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.cfg[0].pin_three[2:0] == 3'h3 |=> !pin_oe[0][2])
    else $error("pin three input drives");
  remote_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state.cfg[0].pair_one_two[2:0] == 3'h5)[*2] ##0 link_lost_s |=>
      $stable(pin_out[0][0]))
    else $error("remote hold lost level");
  remote_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    link_detect[0] && state.cfg[0].pair_one_two[2:0] == 3'h5 |=> pin_oe[0][0] &&
      pin_out[0][0] == $past(state.remote_level[0][0]))
    else $error("remote level not driven");
  remote_default_a: assert property (@(posedge clk) disable iff (!arst_n)
    !link_detect[0] && state.cfg[0].pair_one_two[2:0] == 3'h7 |=>
      pin_oe[0][0] && pin_out[0][0] == $past(state.cfg[0].pair_one_two[3]))
    else $error("remote default value wrong");
  second_default_a: assert property (@(posedge clk) disable iff (!arst_n)
    !link_detect[1] && state.cfg[1].pair_one_two[6:4] == 3'h7 |=>
      pin_oe[1][1] && pin_out[1][1] == $past(state.cfg[1].pair_one_two[7]))
    else $error("second port default value wrong");
  port_select_a: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && second_port_select && req.addr == 8'h0E |=>
      state.cfg[1].pair_one_two == $past(req.wdata))
    else $error("second port write missed");
  reg_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.cfg[0].pair_five_six[5:4] == 2'h1 |=> pin_oe[0][4] &&
      pin_out[0][4] == $past(state.cfg[0].pair_five_six[7]))
    else $error("pin six output wrong");
  remote_update_a: assert property (@(posedge clk) disable iff (!arst_n)
    remote_valid[0] |=> state.remote_level[0] == $past(remote_level[0]))
    else $error("remote level not taken");

endmodule

//--- src/lpm_pkg.sv
// Purpose: Shared constants and types for the link pin mode control block.
// Assumes: Registers are 8 bits wide and reached over a simple byte port.
// Notes: Offsets are the byte addresses of the serial control bus.
package lpm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PAIR_ONE_TWO_OFFSET = 8'h0E;
  localparam logic [7:0] PIN_THREE_OFFSET = 8'h0F;
  localparam logic [7:0] PAIR_FIVE_SIX_OFFSET = 8'h10;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int HI_VALUE_BIT = 7;
  localparam int HI_MODE_LSB = 4;
  localparam int LO_VALUE_BIT = 3;
  localparam int LO_MODE_LSB = 0;

  // ----------------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_LOCAL_OUT = 3'h1;
  localparam logic [2:0] MODE_LOCAL_IN = 3'h3;
  localparam logic [2:0] MODE_REMOTE_HOLD = 3'h5;
  localparam logic [2:0] MODE_REMOTE_DEFAULT = 3'h7;
  localparam logic [1:0] MODE_FUNC_IN_LOW = 2'h0;
  localparam logic [1:0] MODE_TRISTATE_LOW = 2'h2;
  localparam logic [1:0] SHORT_FUNC_IN = 2'h0;
  localparam logic [1:0] SHORT_OUT = 2'h1;
  localparam logic [1:0] SHORT_TRISTATE = 2'h2;

  // Register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpm_req_t;

  // Per-port configuration bytes.
  typedef struct packed {
    logic [7:0] pair_one_two;
    logic [7:0] pin_three;
    logic [7:0] pair_five_six;
  } lpm_port_cfg_t;

  // Whole block state.
  typedef struct packed {
    lpm_port_cfg_t [1:0] cfg;
    logic [1:0][2:0] remote_level;
    logic [1:0][2:0] held_level;
    logic [1:0][4:0] pin_out;
    logic [1:0][4:0] pin_oe;
    logic [1:0][4:0] pin_sampled;
    logic [7:0] rdata;
  } lpm_state_t;

endpackage

//--- dv/lpm_remote_model.sv
// Purpose: Remote receiver model that feeds link detect and remote pin levels.
// Assumes: Bench commands are synchronous to clk.
// Notes: Levels flip every cycle outside a valid pulse, so stale values never look right.
`timescale 1ns/1ps
module lpm_remote_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] link_cmd,
  input wire logic [1:0] send_cmd,
  input wire logic [1:0][2:0] send_level,
  output logic [1:0] link_detect,
  output logic [1:0] remote_valid,
  output logic [1:0][2:0] remote_level
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_detect <= '0;
      remote_valid <= '0;
      remote_level <= '0;
    end else begin
      link_detect <= link_cmd;
      remote_valid <= send_cmd & link_cmd;
      for (int i = 0; i < 2; i++) begin
        remote_level[i] <= (send_cmd[i] && link_cmd[i]) ? send_level[i] : ~remote_level[i];
      end
    end
  end
endmodule

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the link pin mode control block.
// Assumes: Register accesses use single-cycle strobes.
// Notes: Every mode code is tried on both ports, linked and unlinked.
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic arst_n;
  logic second_port_select;
  lpm_pkg::lpm_req_t req;
  logic [7:0] rdata;
  logic [1:0] link_detect, remote_valid, link_cmd, send_cmd;
  logic [1:0][2:0] remote_level, send_level, functional_in;
  logic [1:0][4:0] pin_in, pin_out, pin_oe, pin_sampled;
  integer seed = 32'hEF638F46;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] mask [3] = '{8'hFF, 8'h0F, 8'hBB};

  lpm_link_pin_mode_control dut (.clk(clk), .arst_n(arst_n),
    .second_port_select(second_port_select), .req(req), .rdata(rdata),
    .link_detect(link_detect), .remote_valid(remote_valid), .remote_level(remote_level),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_sampled(pin_sampled),
    .functional_in(functional_in));
  lpm_remote_model partner (.clk(clk), .arst_n(arst_n), .link_cmd(link_cmd),
    .send_cmd(send_cmd), .send_level(send_level), .link_detect(link_detect),
    .remote_valid(remote_valid), .remote_level(remote_level));

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) req.rd <= 1'b0;
    @(negedge clk) chk("rdata", exp, rdata);
  endtask

  // Works out pin enables and levels from the mode code, value bits and link state.
  task automatic check_pins(input int p, input logic [2:0] c, input logic [2:0] v,
                            input logic [2:0] r, input logic lk);
    logic [4:0] eo;
    logic [4:0] ev;
    for (int i = 0; i < 3; i++) begin
      eo[i] = c[0] && c != 3'h3;
      ev[i] = (c == 3'h1 || (c == 3'h7 && !lk)) ? v[i] : r[i];
    end
    eo[4:3] = {2{c[1:0] == 2'h1}};
    ev[4:3] = v[1:0];
    @(negedge clk) chk("pin_oe", 8'(eo), 8'(pin_oe[p]));
    chk("pin_out", 8'(ev & eo), 8'(pin_out[p] & eo));
    chk("functional_in", {5'h00, {2{c[1:0] == 2'h0}}, 1'b0}, 8'(functional_in[p]));
    if (c == 3'h3) begin
      chk("pin_sampled", 8'(pin_in[p]), 8'(pin_sampled[p]));
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial begin : main
    logic [7:0] d;
    logic [7:0] cfg [2][3];
    logic [2:0] v;
    logic [2:0] r;
    logic [2:0] r2;
    arst_n = 1'b0;
    second_port_select = 1'b0;
    req = '0;
    link_cmd = '0;
    send_cmd = '0;
    send_level = '0;
    pin_in = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      second_port_select <= p[0];
      for (int a = 0; a < 3; a++) begin
        rd_chk(8'h0E + 8'(a), 8'h00);
      end
      chk("reset oe", 8'h00, 8'(pin_oe[p]));
    end
    wr(8'h11, 8'hFF);
    rd_chk(8'h11, 8'h00);
    for (int p = 0; p < 2; p++) begin
      second_port_select <= p[0];
      for (int a = 0; a < 3; a++) begin
        d = 8'($random(seed));
        cfg[p][a] = d & mask[a];
        wr(8'h0E + 8'(a), d);
      end
    end
    for (int p = 0; p < 2; p++) begin
      second_port_select <= p[0];
      for (int a = 0; a < 3; a++) begin
        rd_chk(8'h0E + 8'(a), cfg[p][a]);
      end
    end
    for (int p = 0; p < 2; p++) begin
      second_port_select <= p[0];
      for (int c = 0; c < 8; c++) begin
        v = 3'($random(seed));
        r = 3'($random(seed));
        r2 = 3'($random(seed));
        link_cmd[p] <= 1'b1;
        wr(8'h0E, {v[1], c[2:0], v[0], c[2:0]});
        wr(8'h0F, {4'h0, v[2], c[2:0]});
        wr(8'h10, {v[1], 1'b0, c[1:0], v[0], 1'b0, c[1:0]});
        pin_in[p] <= 5'($random(seed));
        send_level[p] <= r;
        send_cmd[p] <= 1'b1;
        @(posedge clk) send_cmd[p] <= 1'b0;
        repeat (6) @(posedge clk);
        check_pins(p, c[2:0], v, r, 1'b1);
        // A last level arrives as the link drops; a held pin must not show it.
        send_level[p] <= r2;
        send_cmd[p] <= 1'b1;
        @(posedge clk) send_cmd[p] <= 1'b0;
        link_cmd[p] <= 1'b0;
        repeat (4) @(posedge clk);
        check_pins(p, c[2:0], v, r, 1'b0);
      end
    end
    finish_test();
  end
endmodule
